// ==== rtl/scfg_pkg.sv ====
// Shared constants and carrier types for the system configuration bank
// Assumes a 100 MHz clock and an AXI4-Lite master with 32-bit data
package scfg_pkg;
	timeunit 1ns;
	timeprecision 1ps;
	// ******************************
	// Bus shape
	// ******************************
	localparam int AXI_AW = 12;
	localparam int AXI_DW = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CLK_MODE = 8'h40;
	localparam logic [7:0] IDX_SETUP = 8'h41;
	localparam logic [7:0] IDX_VALID = 8'h42;
	localparam logic [7:0] IDX_SWITCH = 8'h43;
	localparam logic [7:0] IDX_NMI_B0 = 8'h44;
	localparam logic [7:0] IDX_NMI_B1 = 8'h45;
	localparam logic [7:0] IDX_NMI_B2 = 8'h46;
	localparam logic [7:0] IDX_NMI_B3 = 8'h47;
	localparam logic [7:0] IDX_REFRESH = 8'h48;
	localparam logic [7:0] IDX_REF_CTRL = 8'h49;
	localparam logic [7:0] IDX_NMI_CTRL = 8'h4a;
	// Reset values and implemented-bit masks
	localparam logic [7:0] RST_CLK_MODE = 8'h04;
	localparam logic [7:0] RST_SWITCH = 8'h30;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] MASK_CLK_MODE = 8'hdc;
	localparam logic [7:0] MASK_SETUP = 8'h0c;
	localparam logic [7:0] MASK_VALID = 8'h01;
	localparam logic [7:0] MASK_REF_CTRL = 8'h02;
	localparam logic [7:0] MASK_NMI_CTRL = 8'h40;
	// Field positions
	localparam int BIT_SPEED = 7;
	localparam int BIT_DUTY = 6;
	localparam int BIT_DUAL_OSC = 4;
	localparam int BIT_DMA_HALVE = 3;
	localparam int BIT_BUS16 = 2;
	localparam int BIT_MEM_KIND = 3;
	localparam int BIT_SOFT_RST = 2;
	localparam int BIT_VALID = 0;
	localparam int BIT_COPRO = 1;
	localparam int BIT_REF_RUN = 1;
	localparam int BIT_NMI_OVR = 6;
	// ******************************
	// Timing
	// ******************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int PS_LOW_MIN_NS = 20;
	localparam logic [1:0] PS_LOW_CYC = 2'((PS_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int REF_UNIT_NS = 838;
	localparam int REF_UNIT_CYC = (REF_UNIT_NS + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
	localparam logic [6:0] REF_UNIT_LAST = 7'(REF_UNIT_CYC - 1);
	localparam logic [7:0] REF_INVALID = 8'h00;
	// ******************************
	// Carriers
	// ******************************
	typedef struct packed {
		logic awvalid;
		logic [AXI_AW-1:0] awaddr;
		logic wvalid;
		logic [AXI_DW-1:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [AXI_AW-1:0] araddr;
		logic rready;
	} scfg_axi_req_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [AXI_DW-1:0] rdata;
		logic [1:0] rresp;
	} scfg_axi_rsp_t;
	typedef struct packed {
		logic cpu_fast;
		logic duty_50;
		logic dual_osc;
		logic dma_halve;
		logic bus_16bit;
		logic mem_sram;
		logic soft_reset_en;
	} scfg_clk_ctrl_t;
endpackage

// ==== rtl/scfg_refresh_timer.sv ====
// Refresh interval timer counting in 838 ns units
// Assumes interval and run enable come from registers on the same clock
module scfg_refresh_timer (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Control
	input wire logic run_en_i,
	input wire logic [7:0] interval_i,
	// Refresh request, one-cycle pulse
	output logic refresh_req_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import scfg_pkg::*;

	typedef struct packed {
		logic [6:0] unit_cnt;
		logic [7:0] left;
		logic req;
	} scfg_rt_state_t;

	scfg_rt_state_t st_r;
	scfg_rt_state_t st_nxt;

	// Prescale to the unit, then count units down to the interval end
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.req = 1'b0;
		if (!run_en_i || interval_i == REF_INVALID)
		begin
			st_nxt.unit_cnt = '0;
			st_nxt.left = '0;
		end
		else if (st_r.left == '0)
		begin
			st_nxt.left = interval_i;
			st_nxt.unit_cnt = '0;
		end
		else if (st_r.unit_cnt == REF_UNIT_LAST)
		begin
			st_nxt.unit_cnt = '0;
			if (st_r.left == 8'h01)
			begin
				st_nxt.req = 1'b1;
				st_nxt.left = interval_i;
			end
			else
			begin
				st_nxt.left = st_r.left - 8'h01;
			end
		end
		else
		begin
			st_nxt.unit_cnt = st_r.unit_cnt + 7'h01;
		end
	end

	// State register
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign refresh_req_o = st_r.req;
endmodule // scfg_refresh_timer

// ==== rtl/scfg_regs.sv ====
// System configuration register bank behind an AXI4-Lite slave
// Assumes one clock; power sense arrives asynchronously from a pin
module scfg_regs (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Register bus
	input wire scfg_pkg::scfg_axi_req_t axi_req_i,
	output scfg_pkg::scfg_axi_rsp_t axi_rsp_o,
	// Pins and system side inputs
	input wire logic power_sense_input_i,
	input wire logic nmi_ack_i,
	input wire logic [31:0] mem_nmi_vector_i,
	// Clock and mode controls
	output scfg_pkg::scfg_clk_ctrl_t clk_ctrl_o,
	output logic dma_clk_en_o,
	output logic bus_request_grant_line_sel_o,
	output logic setup_valid_flag_o,
	// NMI vector answer
	output logic [31:0] nmi_vector_o,
	output logic nmi_vector_valid_o,
	// Refresh
	output logic refresh_req_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import scfg_pkg::*;

	// ******************************
	// State
	// ******************************

	typedef struct packed {
		// Bus side
		logic aw_held;
		logic [7:0] aw_idx;
		logic w_held;
		logic [7:0] w_byte;
		logic w_lane0;
		scfg_axi_rsp_t rsp;
		// Registers
		logic [7:0] clk_mode;
		logic [7:0] setup;
		logic [7:0] valid;
		logic [7:0] switch_emu;
		logic [31:0] nmi_vec;
		logic [7:0] refresh_interval;
		logic [7:0] ref_ctrl;
		logic [7:0] nmi_ctrl;
		// Power sense filter
		logic ps_meta;
		logic ps_sync;
		logic [1:0] ps_low_cnt;
		// Registered outputs
		scfg_clk_ctrl_t clk_out;
		logic dma_en;
		logic rqgt_sel;
		logic [31:0] nmi_out;
		logic nmi_out_valid;
	} scfg_state_t;

	scfg_state_t st_r;
	scfg_state_t st_nxt;

	// ******************************
	// Helpers
	// ******************************

	// True for every index that holds a register
	function automatic logic idx_mapped(input logic [7:0] idx);
		logic hit;
		hit = 1'b0;
		if (idx == IDX_CLK_MODE)
			hit = 1'b1;
		else if (idx == IDX_SETUP)
			hit = 1'b1;
		else if (idx >= IDX_VALID && idx <= IDX_NMI_CTRL)
			hit = 1'b1;
		return hit;
	endfunction

	// Read value of one register; reserved bits come back as zero
	function automatic logic [7:0] reg_read(input scfg_state_t s, input logic [7:0] idx);
		logic [7:0] v;
		v = RST_ZERO;
		if (idx == IDX_CLK_MODE)
			v = s.clk_mode;
		else if (idx == IDX_SETUP)
			v = s.setup;
		else if (idx == IDX_VALID)
			v = s.valid;
		else if (idx == IDX_SWITCH)
			v = s.switch_emu;
		else if (idx == IDX_NMI_B0)
			v = s.nmi_vec[7:0];
		else if (idx == IDX_NMI_B1)
			v = s.nmi_vec[15:8];
		else if (idx == IDX_NMI_B2)
			v = s.nmi_vec[23:16];
		else if (idx == IDX_NMI_B3)
			v = s.nmi_vec[31:24];
		else if (idx == IDX_REFRESH)
			v = s.refresh_interval;
		else if (idx == IDX_REF_CTRL)
			v = s.ref_ctrl;
		else if (idx == IDX_NMI_CTRL)
			v = s.nmi_ctrl;
		return v;
	endfunction

	// ******************************
	// Next state
	// ******************************

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.nmi_out_valid = 1'b0;

		// Responses retire when the master takes them
		if (st_r.rsp.bvalid && axi_req_i.bready)
		begin
			st_nxt.rsp.bvalid = 1'b0;
		end
		if (st_r.rsp.rvalid && axi_req_i.rready)
		begin
			st_nxt.rsp.rvalid = 1'b0;
		end

		// Address and data are caught separately, in either order
		if (axi_req_i.awvalid && st_r.rsp.awready)
		begin
			st_nxt.aw_held = 1'b1;
			st_nxt.aw_idx = axi_req_i.awaddr[9:2];
		end
		if (axi_req_i.wvalid && st_r.rsp.wready)
		begin
			st_nxt.w_held = 1'b1;
			st_nxt.w_byte = axi_req_i.wdata[7:0];
			st_nxt.w_lane0 = axi_req_i.wstrb[0];
		end

		// Write completes once both halves are held; only the index bits decode
		if (st_nxt.aw_held && st_nxt.w_held && !st_r.rsp.bvalid)
		begin
			st_nxt.aw_held = 1'b0;
			st_nxt.w_held = 1'b0;
			st_nxt.rsp.bvalid = 1'b1;
			st_nxt.rsp.bresp = RESP_OKAY;
			if (!idx_mapped(st_nxt.aw_idx))
			begin
				st_nxt.rsp.bresp = RESP_SLVERR;
			end
			else if (!st_nxt.w_lane0)
			begin
				// Byte lane 0 off: nothing is stored
				st_nxt.rsp.bresp = RESP_OKAY;
			end
			else if (st_nxt.aw_idx == IDX_CLK_MODE)
			begin
				st_nxt.clk_mode = st_nxt.w_byte & MASK_CLK_MODE;
			end
			else if (st_nxt.aw_idx == IDX_SETUP)
			begin
				st_nxt.setup = st_nxt.w_byte & MASK_SETUP;
			end
			else if (st_nxt.aw_idx == IDX_VALID)
			begin
				st_nxt.valid = st_nxt.w_byte & MASK_VALID;
			end
			else if (st_nxt.aw_idx == IDX_SWITCH)
			begin
				st_nxt.switch_emu = st_nxt.w_byte;
			end
			else if (st_nxt.aw_idx == IDX_NMI_B0)
			begin
				st_nxt.nmi_vec[7:0] = st_nxt.w_byte;
			end
			else if (st_nxt.aw_idx == IDX_NMI_B1)
			begin
				st_nxt.nmi_vec[15:8] = st_nxt.w_byte;
			end
			else if (st_nxt.aw_idx == IDX_NMI_B2)
			begin
				st_nxt.nmi_vec[23:16] = st_nxt.w_byte;
			end
			else if (st_nxt.aw_idx == IDX_NMI_B3)
			begin
				st_nxt.nmi_vec[31:24] = st_nxt.w_byte;
			end
			else if (st_nxt.aw_idx == IDX_REFRESH)
			begin
				st_nxt.refresh_interval = st_nxt.w_byte;
			end
			else if (st_nxt.aw_idx == IDX_REF_CTRL)
			begin
				st_nxt.ref_ctrl = st_nxt.w_byte & MASK_REF_CTRL;
			end
			else if (st_nxt.aw_idx == IDX_NMI_CTRL)
			begin
				st_nxt.nmi_ctrl = st_nxt.w_byte & MASK_NMI_CTRL;
			end
		end

		// Reads answer one cycle after the address is taken
		if (axi_req_i.arvalid && st_r.rsp.arready)
		begin
			st_nxt.rsp.rvalid = 1'b1;
			if (idx_mapped(axi_req_i.araddr[9:2]) && axi_req_i.araddr[11:10] == '0)
			begin
				st_nxt.rsp.rresp = RESP_OKAY;
				st_nxt.rsp.rdata = {24'h000000, reg_read(st_r, axi_req_i.araddr[9:2])};
			end
			else
			begin
				st_nxt.rsp.rresp = RESP_SLVERR;
				st_nxt.rsp.rdata = '0;
			end
		end

		// One write and one read under way at a time
		st_nxt.rsp.awready = !st_nxt.aw_held && !st_nxt.rsp.bvalid;
		st_nxt.rsp.wready = !st_nxt.w_held && !st_nxt.rsp.bvalid;
		st_nxt.rsp.arready = !st_nxt.rsp.rvalid;

		// Power sense: two-stage synchroniser, then a low-time filter
		st_nxt.ps_meta = power_sense_input_i;
		st_nxt.ps_sync = st_r.ps_meta;
		if (st_r.ps_sync)
		begin
			st_nxt.ps_low_cnt = '0;
		end
		else if (st_r.ps_low_cnt != PS_LOW_CYC)
		begin
			st_nxt.ps_low_cnt = st_r.ps_low_cnt + 2'h1;
		end
		// Loss of power outranks a software write in the same cycle
		if (st_nxt.ps_low_cnt == PS_LOW_CYC)
		begin
			st_nxt.valid[BIT_VALID] = 1'b0;
		end

		// Fast speed only takes effect once a second oscillator is declared
		st_nxt.clk_out.cpu_fast = st_r.clk_mode[BIT_SPEED] && st_r.clk_mode[BIT_DUAL_OSC];
		st_nxt.clk_out.duty_50 = st_r.clk_mode[BIT_DUTY];
		st_nxt.clk_out.dual_osc = st_r.clk_mode[BIT_DUAL_OSC];
		st_nxt.clk_out.dma_halve = st_r.clk_mode[BIT_DMA_HALVE];
		st_nxt.clk_out.bus_16bit = st_r.clk_mode[BIT_BUS16];
		st_nxt.clk_out.mem_sram = st_r.setup[BIT_MEM_KIND];
		st_nxt.clk_out.soft_reset_en = st_r.setup[BIT_SOFT_RST];

		// DMA clock enable: every cycle, or every other cycle when halved
		if (st_r.clk_mode[BIT_DMA_HALVE])
		begin
			st_nxt.dma_en = !st_r.dma_en;
		end
		else
		begin
			st_nxt.dma_en = 1'b1;
		end

		// Only the coprocessor bit of the switch byte reaches hardware
		st_nxt.rqgt_sel = st_r.switch_emu[BIT_COPRO];

		// NMI acknowledge: stored vector or the one from memory
		if (nmi_ack_i)
		begin
			st_nxt.nmi_out_valid = 1'b1;
			if (st_r.nmi_ctrl[BIT_NMI_OVR])
			begin
				st_nxt.nmi_out = st_r.nmi_vec;
			end
			else
			begin
				st_nxt.nmi_out = mem_nmi_vector_i;
			end
		end
	end

	// ******************************
	// State register
	// ******************************

	// Reset loads the documented defaults; the valid flag starts at zero
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			st_r <= '0;
			st_r.clk_mode <= RST_CLK_MODE;
			st_r.setup <= RST_ZERO;
			st_r.valid <= RST_ZERO;
			st_r.switch_emu <= RST_SWITCH;
			st_r.ps_meta <= 1'b1;
			st_r.ps_sync <= 1'b1;
			st_r.clk_out.bus_16bit <= 1'b1;
			st_r.dma_en <= 1'b1;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ******************************
	// Refresh timer
	// ******************************

	scfg_refresh_timer u_refresh (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.run_en_i(st_r.ref_ctrl[BIT_REF_RUN]),
		.interval_i(st_r.refresh_interval),
		.refresh_req_o(refresh_req_o)
	);

	// ******************************
	// Outputs, all straight from the state register
	// ******************************

	assign axi_rsp_o = st_r.rsp;
	assign clk_ctrl_o = st_r.clk_out;
	assign dma_clk_en_o = st_r.dma_en;
	assign bus_request_grant_line_sel_o = st_r.rqgt_sel;
	assign setup_valid_flag_o = st_r.valid[BIT_VALID];
	assign nmi_vector_o = st_r.nmi_out;
	assign nmi_vector_valid_o = st_r.nmi_out_valid;
endmodule // scfg_regs

// ==== verif/scfg_regs_monitor.sv ====
// Concurrent checks on the configuration bank ports
// Assumes one clock domain; bound onto scfg_regs below
module scfg_regs_monitor (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Observed ports
	input wire scfg_pkg::scfg_axi_req_t axi_req_i,
	input wire scfg_pkg::scfg_axi_rsp_t axi_rsp_o,
	input wire logic power_sense_input_i,
	input wire logic nmi_ack_i,
	input wire scfg_pkg::scfg_clk_ctrl_t clk_ctrl_o,
	input wire logic dma_clk_en_o,
	input wire logic setup_valid_flag_o,
	input wire logic nmi_vector_valid_o,
	input wire logic refresh_req_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import scfg_pkg::*;
	// ******************************
	// Properties
	// ******************************
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	a_nmi_answer: assert property (nmi_ack_i |=> nmi_vector_valid_o)
		else $error("nmi answer missing");
	a_nmi_cause: assert property (nmi_vector_valid_o |-> $past(nmi_ack_i))
		else $error("nmi answer without acknowledge");
	// Sync and filter delay fit inside seven low samples
	a_valid_sense: assert property (!power_sense_input_i [*7] |-> !setup_valid_flag_o)
		else $error("valid flag survived power loss");
	a_fast_dual: assert property (clk_ctrl_o.cpu_fast |-> clk_ctrl_o.dual_osc)
		else $error("fast clock without second oscillator");
	a_dma_full: assert property (!clk_ctrl_o.dma_halve && !$past(clk_ctrl_o.dma_halve)
		&& !$past(clk_ctrl_o.dma_halve, 2) |-> dma_clk_en_o)
		else $error("dma enable gaps at full rate");
	a_dma_half: assert property (clk_ctrl_o.dma_halve && $past(clk_ctrl_o.dma_halve)
		&& $past(clk_ctrl_o.dma_halve, 2) |-> dma_clk_en_o != $past(dma_clk_en_o))
		else $error("dma enable not halved");
	a_refresh_gap: assert property (refresh_req_o |=> !refresh_req_o [*8])
		else $error("refresh pulses too close");
	a_write_answer: assert property (axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid
		&& axi_rsp_o.wready |=> axi_rsp_o.bvalid)
		else $error("write response late");
	a_read_answer: assert property (axi_req_i.arvalid && axi_rsp_o.arready |=> axi_rsp_o.rvalid)
		else $error("read response late");
endmodule // scfg_regs_monitor

bind scfg_regs scfg_regs_monitor u_scfg_regs_monitor (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
	.axi_req_i(axi_req_i), .axi_rsp_o(axi_rsp_o), .power_sense_input_i(power_sense_input_i),
	.nmi_ack_i(nmi_ack_i), .clk_ctrl_o(clk_ctrl_o), .dma_clk_en_o(dma_clk_en_o),
	.setup_valid_flag_o(setup_valid_flag_o), .nmi_vector_valid_o(nmi_vector_valid_o),
	.refresh_req_o(refresh_req_o));

// ==== verif/scfg_host_model.sv ====
// Host software model: AXI4-Lite master for register accesses
// Assumes tasks are called right after a rising edge, one at a time
module scfg_host_model (
	// Clock
	input wire logic clk_i,
	// Register bus
	output scfg_pkg::scfg_axi_req_t axi_req_o,
	input wire scfg_pkg::scfg_axi_rsp_t axi_rsp_i
);
	timeunit 1ns;
	timeprecision 1ps;
	import scfg_pkg::*;
	// Write strobes; the bench may narrow them for one write
	logic [3:0] wr_strb;
	// ******************************
	// Bus cycles
	// ******************************
	// Response ready held high, so a response retires at the edge it is seen
	initial
	begin
		axi_req_o = '0;
		axi_req_o.bready = 1'b1;
		axi_req_o.rready = 1'b1;
		wr_strb = 4'hf;
	end
	// Address and data offered together, each released once taken
	task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] resp,
		output bit to);
		bit aw;
		bit w;
		aw = 1'b0;
		w = 1'b0;
		to = 1'b1;
		axi_req_o.awvalid <= 1'b1;
		axi_req_o.awaddr <= a;
		axi_req_o.wvalid <= 1'b1;
		axi_req_o.wdata <= {24'h000000, d};
		axi_req_o.wstrb <= wr_strb;
		for (int n = 0; n < 200 && to; n++)
		begin
			@(posedge clk_i);
			if (axi_rsp_i.bvalid)
			begin
				resp = axi_rsp_i.bresp;
				to = 1'b0;
			end
			if (!aw && axi_rsp_i.awready)
			begin
				aw = 1'b1;
				axi_req_o.awvalid <= 1'b0;
			end
			if (!w && axi_rsp_i.wready)
			begin
				w = 1'b1;
				axi_req_o.wvalid <= 1'b0;
			end
		end
	endtask
	task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] resp,
		output bit to);
		bit ar;
		ar = 1'b0;
		to = 1'b1;
		axi_req_o.arvalid <= 1'b1;
		axi_req_o.araddr <= a;
		for (int n = 0; n < 200 && to; n++)
		begin
			@(posedge clk_i);
			if (axi_rsp_i.rvalid)
			begin
				d = axi_rsp_i.rdata[7:0];
				resp = axi_rsp_i.rresp;
				to = 1'b0;
			end
			if (!ar && axi_rsp_i.arready)
			begin
				ar = 1'b1;
				axi_req_o.arvalid <= 1'b0;
			end
		end
	endtask
endmodule // scfg_host_model

// ==== verif/system_config_registers_tb_top.sv ====
// Self-checking bench for the configuration register bank
// Assumes the host model drives the bus; the checker is bound in
module system_config_registers_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import scfg_pkg::*;
	typedef struct packed {logic [11:0] a; logic [7:0] d; logic [7:0] q;} scfg_row_t;
	// Byte address, written value, value read back
	localparam scfg_row_t ROWS [10] = '{'{12'h100, 8'hff, 8'hdc}, '{12'h104, 8'hff, 8'h0c},
		'{12'h108, 8'hff, 8'h01}, '{12'h10c, 8'ha5, 8'ha5}, '{12'h110, 8'h11, 8'h11},
		'{12'h114, 8'h22, 8'h22}, '{12'h118, 8'h33, 8'h33}, '{12'h11c, 8'h44, 8'h44},
		'{12'h124, 8'hff, 8'h02}, '{12'h128, 8'hff, 8'h40}};
	localparam logic [7:0] RST [11] = '{8'h04, 8'h00, 8'h00, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00};
	logic clk_i, sys_rst_i, ps, nmi_ack, dma_en, rgt, vflag, nval, rreq;
	logic [31:0] mem_vec, nvec;
	scfg_axi_req_t axi_req;
	scfg_axi_rsp_t axi_rsp;
	scfg_clk_ctrl_t clk_ctrl;
	int err_total, n_checks, c;
	scfg_regs u_scfg_regs (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .axi_req_i(axi_req),
		.axi_rsp_o(axi_rsp), .power_sense_input_i(ps), .nmi_ack_i(nmi_ack),
		.mem_nmi_vector_i(mem_vec), .clk_ctrl_o(clk_ctrl), .dma_clk_en_o(dma_en),
		.bus_request_grant_line_sel_o(rgt), .setup_valid_flag_o(vflag), .nmi_vector_o(nvec),
		.nmi_vector_valid_o(nval), .refresh_req_o(rreq));
	scfg_host_model u_scfg_host_model (.clk_i(clk_i), .axi_req_o(axi_req), .axi_rsp_i(axi_rsp));
	// ******************************
	// Helpers
	// ******************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wreg(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		logic [1:0] r;
		bit to;
		u_scfg_host_model.wr(a, d, r, to);
		if (to)
		begin
			err_total++;
			wrap_up();
		end
		chk({30'h0, r}, {30'h0, er});
	endtask
	task automatic rchk(input logic [11:0] a, input logic [7:0] q, input logic [1:0] er);
		logic [7:0] d;
		logic [1:0] r;
		bit to;
		u_scfg_host_model.rd(a, d, r, to);
		if (to)
		begin
			err_total++;
			wrap_up();
		end
		chk({22'h0, r, d}, {22'h0, er, q});
	endtask
	// Derived outputs land at the edge the response is seen; the check waits two more edges
	task automatic ctrl(input logic [11:0] a, input logic [7:0] d, input logic [6:0] q);
		wreg(a, d, RESP_OKAY);
		repeat (2) @(posedge clk_i);
		chk({25'h0, clk_ctrl}, {25'h0, q});
	endtask
	task automatic nmi(input logic [31:0] exp);
		nmi_ack <= 1'b1;
		@(posedge clk_i);
		nmi_ack <= 1'b0;
		@(posedge clk_i);
		chk({nval, nvec[30:0]}, {1'b1, exp[30:0]});
		chk(nvec, exp);
	endtask
	// Edges until a refresh pulse is seen, lim if none
	task automatic gap(input int lim, output int n);
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (rreq !== 1'b1 && n < lim);
	endtask
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial
	begin
		repeat (100000) @(posedge clk_i);
		err_total++;
		wrap_up();
	end
	// ******************************
	// Sequence
	// ******************************
	initial
	begin
		{sys_rst_i, ps, nmi_ack, mem_vec} = {3'b110, 32'hcafef00d};
		err_total = 0;
		n_checks = 0;
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		foreach (ROWS[i])
		begin
			wreg(ROWS[i].a, ROWS[i].d, RESP_OKAY);
			rchk(ROWS[i].a, ROWS[i].q, RESP_OKAY);
		end
		$display("rows done");
		// Second reset in mid-run restores every default
		sys_rst_i <= 1'b1;
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		for (int i = 0; i < 11; i++)
			rchk(12'h100 + 12'(i * 4), RST[i], RESP_OKAY);
		chk({25'h0, clk_ctrl}, 32'h04);
		chk({30'h0, rgt, vflag}, 32'h0);
		$display("reset done");
		ctrl(12'h100, 8'h80, 7'h00);
		ctrl(12'h100, 8'h10, 7'h10);
		ctrl(12'h100, 8'h90, 7'h50);
		ctrl(12'h100, 8'h4c, 7'h2c);
		ctrl(12'h104, 8'h0c, 7'h2f);
		wreg(12'h10c, 8'h32, RESP_OKAY);
		repeat (2) @(posedge clk_i);
		chk({31'h0, rgt}, 32'h1);
		// Lane 0 strobe off: the write is answered but stores nothing
		u_scfg_host_model.wr_strb = 4'he;
		wreg(12'h10c, 8'h00, RESP_OKAY);
		u_scfg_host_model.wr_strb = 4'hf;
		rchk(12'h10c, 8'h32, RESP_OKAY);
		$display("clock and switch done");
		wreg(12'h108, 8'h01, RESP_OKAY);
		repeat (20) @(posedge clk_i);
		chk({31'h0, vflag}, 32'h1);
		ps <= 1'b0;
		repeat (8) @(posedge clk_i);
		ps <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk({31'h0, vflag}, 32'h0);
		rchk(12'h108, 8'h00, RESP_OKAY);
		$display("power sense done");
		for (int i = 0; i < 4; i++)
			wreg(12'h110 + 12'(i * 4), 8'(8'h11 * (i + 1)), RESP_OKAY);
		nmi(32'hcafef00d);
		wreg(12'h128, 8'h40, RESP_OKAY);
		nmi(32'h44332211);
		$display("nmi done");
		wreg(12'h120, 8'h02, RESP_OKAY);
		wreg(12'h124, 8'h02, RESP_OKAY);
		gap(400, c);
		gap(400, c);
		chk(32'(c), 32'(2 * REF_UNIT_CYC));
		wreg(12'h120, 8'h00, RESP_OKAY);
		repeat (4) @(posedge clk_i);
		gap(600, c);
		chk(32'(c), 32'd600);
		wreg(12'h120, 8'h01, RESP_OKAY);
		wreg(12'h124, 8'h00, RESP_OKAY);
		repeat (4) @(posedge clk_i);
		gap(600, c);
		chk(32'(c), 32'd600);
		$display("refresh done");
		rchk(12'h130, 8'h00, RESP_SLVERR);
		rchk(12'h500, 8'h00, RESP_SLVERR);
		wreg(12'h130, 8'hff, RESP_SLVERR);
		$display("unmapped done");
		wrap_up();
	end
endmodule // system_config_registers_tb_top
